// *** rtl/tcd_top.v ***
// The strobed register port and the placing of the registers were left to the implementer.
`default_nettype none
`include "tcd_defs.vh"
module tcd_top (
	input wire sys_clk,
	input wire rst,
	input wire [4:0] reg_addr,
	input wire [31:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [31:0] reg_rdata_r,
	input wire [31:0] counter_value,
	input wire [3:0] capture,
	input wire update,
	output reg [3:0] chan_output_r,
	output reg [4:0] win_index_r,
	output reg [4:0] win_target_r,
	output reg win_valid_r,
	output reg [15:0] win_data_r
);
	// ====================================================================
	// Control registers
	reg ext_r;
	reg [7:0] cfg_r;
	reg [3:0] bufen_r;
	reg [12:0] dma_burst_control_r;
	wire [31:0] val [0:3];
	wire [3:0] match;
	wire [4:0] dma_len = dma_burst_control_r[`TCD_DMA_LEN_HI:`TCD_DMA_LEN_LO];
	wire [4:0] dma_ofs = dma_burst_control_r[`TCD_DMA_OFS_HI:`TCD_DMA_OFS_LO];
	wire win_acc = (reg_wr | reg_rd) && (reg_addr == `TCD_OFS_DMAWIN);
	wire [4:0] target = dma_ofs + win_index_r;
	wire [4:0] eff_addr = win_acc ? target : reg_addr;
	wire eff_wr = reg_wr;
	wire [3:0] chwr;
	wire bw_ready;
	wire bw_valid;
	wire [15:0] bw_data;
	genvar g;
	generate
		for (g = 0; g < 4; g = g + 1) begin : gch
			assign chwr[g] = eff_wr && (eff_addr == `TCD_OFS_CH1 + g);
			tcd_channel u_ch (
				.sys_clk(sys_clk),
				.rst(rst),
				.cfg(cfg_r[2*g+1:2*g]),
				.buf_en(bufen_r[g]),
				.ext_en(ext_r),
				.counter_value(counter_value),
				.capture(capture[g]),
				.update(update),
				.wr(chwr[g]),
				.wdata(reg_wdata),
				.value(val[g]),
				.match_r(match[g])
			);
		end
	endgenerate
	// ====================================================================
	// Window trace buffer; a window access made while both entries are full loses its trace word
	tcd_buf2 #(.W(16)) u_buf (
		.sys_clk(sys_clk),
		.rst(rst),
		.in_valid(win_acc),
		.in_ready(bw_ready),
		.in_data(reg_wdata[15:0]),
		.out_valid(bw_valid),
		// Trace register drains a word every cycle, so back-to-back accesses never jam
		.out_ready(1'b1),
		.out_data(bw_data)
	);
	// ====================================================================
	// Register writes and window index
	always @(posedge sys_clk) begin
		if (rst) begin
			ext_r <= 1'b0;
			cfg_r <= 8'h00;
			bufen_r <= 4'h0;
			dma_burst_control_r <= 13'h0000;
			win_index_r <= 5'h00;
			win_target_r <= 5'h00;
			chan_output_r <= 4'h0;
			win_valid_r <= 1'b0;
			win_data_r <= 16'h0000;
		end else begin
			chan_output_r <= match;
			win_valid_r <= bw_valid;
			if (bw_valid) begin
				win_data_r <= bw_data;
			end
			if (eff_wr) begin
				case (eff_addr)
					`TCD_OFS_MODE: ext_r <= reg_wdata[`TCD_MODE_EXT_BIT];
					`TCD_OFS_CFG: cfg_r <= reg_wdata[7:0];
					`TCD_OFS_BUFEN: bufen_r <= reg_wdata[3:0];
					`TCD_OFS_DMA_BURST_CONTROL: dma_burst_control_r <= reg_wdata[12:0] & `TCD_DMA_BURST_CONTROL_MASK;
					default: ;
				endcase
			end
			if (reg_wr && reg_addr == `TCD_OFS_DMA_BURST_CONTROL) begin
				win_index_r <= 5'h00;
			end else if (win_acc && bw_ready) begin
				win_target_r <= target;
				if (win_index_r >= dma_len) begin
					win_index_r <= 5'h00;
				end else begin
					win_index_r <= win_index_r + 5'h01;
				end
			end
		end
	end
	// ====================================================================
	// Read data, one cycle after the strobe
	always @(posedge sys_clk) begin
		if (rst) begin
			reg_rdata_r <= 32'h00000000;
		end else if (reg_rd) begin
			case (eff_addr)
				`TCD_OFS_MODE: reg_rdata_r <= {31'h00000000, ext_r};
				`TCD_OFS_CFG: reg_rdata_r <= {24'h000000, cfg_r};
				`TCD_OFS_BUFEN: reg_rdata_r <= {28'h0000000, bufen_r};
				`TCD_OFS_STATUS: reg_rdata_r <= {23'h000000, win_index_r, chan_output_r};
				`TCD_OFS_CH1: reg_rdata_r <= val[0];
				`TCD_OFS_CH2: reg_rdata_r <= val[1];
				`TCD_OFS_CH3: reg_rdata_r <= val[2];
				`TCD_OFS_CH4: reg_rdata_r <= val[3];
				`TCD_OFS_DMA_BURST_CONTROL: reg_rdata_r <= {19'h00000, dma_burst_control_r};
				default: reg_rdata_r <= 32'h00000000;
			endcase
		end else begin
			reg_rdata_r <= 32'h00000000;
		end
	end
endmodule // tcd_top
`default_nettype wire

// *** rtl/tcd_defs.vh ***
`ifndef TCD_DEFS_VH
`define TCD_DEFS_VH
// ====================================================================
// Register word offsets (byte address = offset * 4)
`define TCD_OFS_MODE 5'h00
`define TCD_OFS_CFG 5'h06
`define TCD_OFS_BUFEN 5'h08
`define TCD_OFS_STATUS 5'h0C
`define TCD_OFS_CH1 5'h0D
`define TCD_OFS_CH2 5'h0E
`define TCD_OFS_CH3 5'h0F
`define TCD_OFS_CH4 5'h10
`define TCD_OFS_DMA_BURST_CONTROL 5'h12
`define TCD_OFS_DMAWIN 5'h13
// ====================================================================
// Field positions
`define TCD_MODE_EXT_BIT 0
`define TCD_DMA_LEN_HI 12
`define TCD_DMA_LEN_LO 8
`define TCD_DMA_OFS_HI 4
`define TCD_DMA_OFS_LO 0
`define TCD_DMA_BURST_CONTROL_MASK 13'h1F1F
`define TCD_CFG_OUTPUT 2'h0
`define TCD_RESET_VAL 32'h00000000
`endif

// *** rtl/tcd_channel.v ***
`default_nettype none
`include "tcd_defs.vh"
module tcd_channel (
	input wire sys_clk,
	input wire rst,
	input wire [1:0] cfg,
	input wire buf_en,
	input wire ext_en,
	input wire [31:0] counter_value,
	input wire capture,
	input wire update,
	input wire wr,
	input wire [31:0] wdata,
	output wire [31:0] value,
	output reg match_r
);
	reg [31:0] value_r;
	reg [31:0] shadow_r;
	reg pend_r;
	wire is_out = (cfg == `TCD_CFG_OUTPUT);
	wire [31:0] wmask = ext_en ? wdata : {16'h0000, wdata[15:0]};
	wire [31:0] cmask = ext_en ? counter_value : {16'h0000, counter_value[15:0]};
	assign value = value_r;
	always @(posedge sys_clk) begin
		if (rst) begin
			value_r <= `TCD_RESET_VAL;
			shadow_r <= `TCD_RESET_VAL;
			pend_r <= 1'b0;
			match_r <= 1'b0;
		end else begin
			match_r <= is_out & (cmask < value_r);
			if (!is_out && capture) begin
				value_r <= cmask;
			end else if (is_out && wr && !buf_en) begin
				value_r <= wmask;
			end else if (is_out && update && pend_r) begin
				value_r <= shadow_r;
			end
			if (wr && buf_en && is_out) begin
				shadow_r <= wmask;
				pend_r <= 1'b1;
			end else if (update) begin
				pend_r <= 1'b0;
			end
		end
	end
endmodule // tcd_channel
`default_nettype wire

// *** rtl/tcd_buf2.v ***
`default_nettype none
module tcd_buf2 #(
	parameter W = 16
) (
	input wire sys_clk,
	input wire rst,
	input wire in_valid,
	output wire in_ready,
	input wire [W-1:0] in_data,
	output wire out_valid,
	input wire out_ready,
	output wire [W-1:0] out_data
);
	reg [W-1:0] mem_r [0:1];
	reg rd_r;
	reg wr_r;
	reg [1:0] cnt_r;
	wire push = in_valid & in_ready;
	wire pop = out_valid & out_ready;
	assign in_ready = (cnt_r != 2'h2);
	assign out_valid = (cnt_r != 2'h0);
	assign out_data = mem_r[rd_r];
	always @(posedge sys_clk) begin
		if (rst) begin
			rd_r <= 1'b0;
			wr_r <= 1'b0;
			cnt_r <= 2'h0;
			mem_r[0] <= {W{1'b0}};
			mem_r[1] <= {W{1'b0}};
		end else begin
			if (push) begin
				mem_r[wr_r] <= in_data;
				wr_r <= ~wr_r;
			end
			if (pop) begin
				rd_r <= ~rd_r;
			end
			cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
		end
	end
endmodule // tcd_buf2
`default_nettype wire

// *** tb/tcd_count_model.sv ***
`default_nettype none
// ====
// Counter core stand-in
module tcd_count_model (
	input wire logic sys_clk,
	input wire logic rst,
	output logic [31:0] counter_value
);
	timeunit 1ns;
	timeprecision 100ps;
	// Starts below the 16-bit edge so a narrow capture shows
	always @(posedge sys_clk) begin
		if (rst)
			counter_value <= 32'h0000FFF0;
		else
			counter_value <= counter_value + 32'h1;
	end
endmodule // tcd_count_model
`default_nettype wire

// *** tb/tcd_top_asserts.sv ***
`default_nettype none
module tcd_chk (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic [4:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [31:0] reg_rdata_r,
	input wire logic [3:0] chan_output_r,
	input wire logic [4:0] win_index_r,
	input wire logic [4:0] win_target_r
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [4:0] len_r;
	logic [4:0] ofs_r;
	wire logic ctl_wr = reg_wr && reg_addr == 5'h12;
	wire logic win_acc = (reg_wr || reg_rd) && reg_addr == 5'h13;
	// ====
	// Shadow of the burst setup
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			len_r <= 5'h00;
			ofs_r <= 5'h00;
		end else if (ctl_wr) begin
			len_r <= reg_wdata[12:8];
			ofs_r <= reg_wdata[4:0];
		end
	end
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);
	sequence s_win;
		win_acc;
	endsequence
	a_rd_idle: assert property (!reg_rd |=> reg_rdata_r == 32'h0)
		else $error("read data not zero when idle");
	a_rd_unmap: assert property (reg_rd && reg_addr == 5'h1F |=> reg_rdata_r == 32'h0)
		else $error("unmapped read not zero");
	a_ctl_clr: assert property (ctl_wr |=> win_index_r == 5'h00)
		else $error("index not cleared");
	a_idx_step: assert property (s_win ##0 win_index_r != len_r |=>
		win_index_r == $past(win_index_r) + 5'h1) else $error("index step wrong");
	a_idx_wrap: assert property (s_win ##0 win_index_r == len_r |=> win_index_r == 5'h00)
		else $error("index did not wrap");
	a_idx_hold: assert property (!win_acc && !ctl_wr |=> $stable(win_index_r))
		else $error("index moved");
	a_win_tgt: assert property (s_win |=>
		win_target_r == $past(ofs_r) + $past(win_index_r)) else $error("bad target");
	a_rst_clear: assert property ($fell(rst) |-> win_index_r == 5'h00 && chan_output_r == 4'h0)
		else $error("outputs not cleared by reset");
endmodule // tcd_chk
`default_nettype wire

// *** tb/tb_top.sv ***
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	logic sys_clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, update = 0, rd_d = 0, win_valid_r;
	logic [4:0] reg_addr = 5'h00, win_index_r, win_target_r;
	logic [31:0] reg_wdata = 32'h0, reg_rdata_r, counter_value, v1, v2, v3;
	logic [3:0] capture = 4'h0, chan_output_r;
	logic [15:0] win_data_r;
	logic [31:0] exp_q[$];
	logic [15:0] trc_q[$];
	int n_fail = 0, n_tests = 0;
	tcd_top tcd_top_inst (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_r(reg_rdata_r),
		.counter_value(counter_value), .capture(capture), .update(update),
		.chan_output_r(chan_output_r), .win_index_r(win_index_r),
		.win_target_r(win_target_r), .win_valid_r(win_valid_r), .win_data_r(win_data_r));
	tcd_count_model tcd_count_model_inst (.sys_clk(sys_clk), .rst(rst),
		.counter_value(counter_value));
	initial forever #12.5 sys_clk = ~sys_clk;
	// ====
	// Bus tasks and checking
	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		if (a == 5'h13)
			trc_q.push_back(d[15:0]);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [4:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
	endtask
	task automatic chk(input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			n_fail++;
			$display("ERROR reg_rdata_r expected %h seen %h", e, g);
		end
	endtask
	task automatic chk_win(input string nm, input logic [15:0] e, input logic [15:0] g);
		n_tests++;
		if (g !== e) begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask
	always @(posedge sys_clk) begin
		rd_d <= reg_rd;
		if (rd_d)
			chk(exp_q.pop_front(), reg_rdata_r);
		if (win_valid_r)
			chk_win("win_data_r", trc_q.size() > 0 ? trc_q.pop_front() : 16'hXXXX, win_data_r);
	end
	task automatic report_and_stop;
		$display("comparisons %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	initial begin
		#(25 * 3000);
		n_fail++;
		report_and_stop();
	end
	initial begin
		void'($urandom(32'h35DD8F8B));
		repeat (3) @(posedge sys_clk);
		rst <= 1'b0;
		for (int i = 0; i < 6; i++)
			rd(5'h0D + 5'(i), 32'h0);
		rd(5'h1F, 32'h0);
		$display("reset test done");
		v1 = $urandom;
		wr(5'h0D, v1);
		rd(5'h0D, {16'h0, v1[15:0]});
		wr(5'h00, 32'h1);
		wr(5'h0D, v1);
		rd(5'h0D, v1);
		$display("width test done");
		// Kept below the counter so channel 2 reads low in the status word
		v2 = $urandom & 32'hFFFF;
		wr(5'h08, 32'h2);
		wr(5'h0E, v2);
		wr(5'h0F, v2);
		rd(5'h0E, 32'h0);
		rd(5'h0F, v2);
		@(posedge sys_clk) update <= 1'b1;
		@(posedge sys_clk) update <= 1'b0;
		rd(5'h0E, v2);
		$display("buffer test done");
		v3 = $urandom & 32'h7FFF;
		wr(5'h08, 32'h0);
		wr(5'h12, 32'h010D);
		for (int i = 0; i < 3; i++)
			wr(5'h13, v3 + i);
		rd(5'h0D, v3 + 2);
		rd(5'h0E, v3 + 1);
		chk_win("trace backlog", 16'h0000, 16'(trc_q.size()));
		$display("burst test done");
		wr(5'h06, 32'h10);
		@(negedge sys_clk) v1 = counter_value + 32'h1;
		@(posedge sys_clk) capture <= 4'h4;
		@(posedge sys_clk) capture <= 4'h0;
		rd(5'h0F, v1);
		wr(5'h0F, ~v1);
		rd(5'h0F, v1);
		wr(5'h10, 32'hFFFFFFFF);
		// Compare result reaches the status word two edges after the write
		repeat (2) @(posedge sys_clk);
		rd(5'h0C, 32'h18);
		$display("channel test done");
		repeat (3) @(posedge sys_clk);
		report_and_stop();
	end
endmodule // tb_top
bind tcd_top tcd_chk tcd_chk_inst (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_r(reg_rdata_r),
	.chan_output_r(chan_output_r), .win_index_r(win_index_r), .win_target_r(win_target_r));
`default_nettype wire
